//--- logic/pvc_regs.vh
`ifndef PVC_REGS_VH
`define PVC_REGS_VH

// register indices on the management port
`define PVC_IDX_MMD_CTRL     5'h0D
`define PVC_IDX_MMD_DATA     5'h0E
`define PVC_IDX_XOVER        5'h1C
`define PVC_IDX_PDTEST       5'h1D
`define PVC_IDX_EXTLPBK      5'h1E
`define PVC_IDX_PHYCTRL      5'h1F

// crossover control fields
`define PVC_XOVER_MANUAL_BIT 7
`define PVC_XOVER_OFF_BIT    6
// power-down / test control fields
`define PVC_PD_CLKOVR_BIT    11
`define PVC_PD_PLLOFF_BIT    10
`define PVC_PD_IOTEST_BIT    7
`define PVC_PD_IOLEVEL_BIT   6
// external loopback field
`define PVC_LPBK_BIT         3
// phy control / status fields
`define PVC_CS_INTPOL_BIT    14
`define PVC_CS_JABBER_BIT    9
`define PVC_CS_SQE_BIT       8
`define PVC_CS_SPD1000_BIT   6
`define PVC_CS_SPD100_BIT    5
`define PVC_CS_SPD10_BIT     4
`define PVC_CS_DUPLEX_BIT    3
`define PVC_CS_MASTER_BIT    2
`define PVC_CS_SWRST_BIT     1
`define PVC_CS_LCFAIL_BIT    0

// reset values
`define PVC_RST_XOVER        16'h0000
`define PVC_RST_PDTEST       16'h0000
`define PVC_RST_EXTLPBK      16'h0000
`define PVC_RST_JABBER       1'b1
`define PVC_RST_SQE          1'b1
`define PVC_RST_MMD_CTRL     16'h0000
`define PVC_RST_MMD_ADDR     16'h0000
`define PVC_RST_INTPOL       1'b0
`define PVC_RST_SWRST        1'b0
`define PVC_RST_LCFAIL       1'b0
`define PVC_RST_RDATA        16'h0000

// portal control layout and function codes
`define PVC_MMD_DEV_MSB      4
`define PVC_MMD_FN_MSB       15
`define PVC_MMD_FN_LSB       14
`define PVC_FN_ADDR          2'h0
`define PVC_FN_DATA          2'h1
`define PVC_FN_INC_RW        2'h2
`define PVC_FN_INC_WR        2'h3

`endif

//--- logic/pvc_mmd_portal.v
`timescale 1ns/1ps
`include "pvc_regs.vh"

module pvc_mmd_portal
(
    input  wire        clk,
    input  wire        rst,
    input  wire        ctrl_wr,
    input  wire        data_wr,
    input  wire        data_rd,
    input  wire [15:0] wdata,
    output wire [15:0] ctrl_val,
    output wire [15:0] data_val,
    output wire [4:0]  mmd_dev,
    output wire [15:0] mmd_reg,
    output wire        mmd_we,
    output wire        mmd_re,
    output wire [15:0] mmd_wdata,
    input  wire [15:0] mmd_rdata
);

    reg  [1:0]  fn_q;
    reg  [1:0]  fn_d;
    reg  [4:0]  dev_q;
    reg  [4:0]  dev_d;
    reg  [15:0] addr_q;
    reg  [15:0] addr_d;
    wire        is_data;

    // any function other than 00 addresses the data path
    assign is_data   = (fn_q != `PVC_FN_ADDR);
    assign ctrl_val  = {fn_q, 9'h000, dev_q};
    assign data_val  = is_data ? mmd_rdata : addr_q;
    assign mmd_dev   = dev_q;
    assign mmd_reg   = addr_q;
    assign mmd_we    = data_wr & is_data;
    assign mmd_re    = data_rd & is_data;
    assign mmd_wdata = wdata;

    // control latch, address latch and post-increment
    always @*
    begin
        fn_d   = fn_q;
        dev_d  = dev_q;
        addr_d = addr_q;
        if (ctrl_wr)
        begin
            fn_d  = wdata[`PVC_MMD_FN_MSB:`PVC_MMD_FN_LSB];
            dev_d = wdata[`PVC_MMD_DEV_MSB:0];
        end
        if (data_wr && !is_data)
            addr_d = wdata;
        else if (data_wr && fn_q[1])
            addr_d = addr_q + 16'h0001;
        else if (data_rd && fn_q == `PVC_FN_INC_RW)
            addr_d = addr_q + 16'h0001;
    end

    // portal state
    always @(posedge clk)
    begin
        if (rst)
        begin
            fn_q   <= `PVC_FN_ADDR;
            dev_q  <= 5'h00;
            addr_q <= `PVC_RST_MMD_ADDR;
        end
        else
        begin
            fn_q   <= fn_d;
            dev_q  <= dev_d;
            addr_q <= addr_d;
        end
    end

endmodule // pvc_mmd_portal

//--- logic/pvc_vendor_ctrl.v
`timescale 1ns/1ps
`include "pvc_regs.vh"

module pvc_vendor_ctrl
(
    input  wire        MCLK,
    input  wire        RST,
    // management register port
    input  wire [4:0]  REG_INDEX,
    input  wire        REG_WR,
    input  wire        REG_RD,
    input  wire [15:0] REG_WDATA,
    output wire [15:0] REG_RDATA,
    output wire        REG_RVALID,
    // indirect register port
    output wire [4:0]  MMD_DEV,
    output wire [15:0] MMD_REG,
    output wire        MMD_WE,
    output wire        MMD_RE,
    output wire [15:0] MMD_WDATA,
    input  wire [15:0] MMD_RDATA,
    // transceiver status
    input  wire        AUTO_MDI_RESULT,
    input  wire        SPEED_1000,
    input  wire        SPEED_100,
    input  wire        SPEED_10,
    input  wire        DUPLEX_FULL,
    input  wire        GIG_MASTER,
    input  wire        LINK_CHECK_FAIL,
    input  wire        POWER_DOWN,
    input  wire        INT_REQ,
    // transceiver controls
    output wire        AUTO_XOVER_EN,
    output wire        MDI_SELECT,
    output wire        CLOCK_GATE,
    output wire        PLL_STOP,
    output wire        IO_TEST_EN,
    output wire        IO_TEST_LEVEL,
    output wire        EXT_LOOPBACK,
    output wire        INT_PIN,
    output wire        JABBER_EN,
    output wire        SQE_TEST_EN,
    output wire        PHY_SOFT_RESET
);

    reg  [15:0] xover_q;
    reg  [15:0] pdtest_q;
    reg  [15:0] lpbk_q;
    reg         intpol_q;
    reg         jabber_q;
    reg         sqe_q;
    reg         swrst_q;
    reg         swrst_d;
    reg         lcfail_q;
    reg         lcfail_d;
    reg  [15:0] rdata_q;
    reg  [15:0] rdata_d;
    reg         rvalid_q;
    reg  [15:0] cs_val;
    wire [15:0] ctrl_val;
    wire [15:0] data_val;
    wire        rd_cs;

    // next values of the writable registers
    reg  [15:0] xover_d;
    reg  [15:0] pdtest_d;
    reg  [15:0] lpbk_d;
    reg         intpol_d;
    reg         jabber_d;
    reg         sqe_d;

    // write selects, one per register
    wire        wr_xover;
    wire        wr_pdtest;
    wire        wr_lpbk;
    wire        wr_cs;

    // one-hot index match
    function hit;
        input [4:0] idx;
        input [4:0] want;
        begin
            hit = (idx == want);
        end
    endfunction

    // register read and write selects
    assign rd_cs     = REG_RD & hit(REG_INDEX, `PVC_IDX_PHYCTRL);
    assign wr_xover  = REG_WR & hit(REG_INDEX, `PVC_IDX_XOVER);
    assign wr_pdtest = REG_WR & hit(REG_INDEX, `PVC_IDX_PDTEST);
    assign wr_lpbk   = REG_WR & hit(REG_INDEX, `PVC_IDX_EXTLPBK);
    assign wr_cs     = REG_WR & hit(REG_INDEX, `PVC_IDX_PHYCTRL);

    // indirect access portal
    pvc_mmd_portal u_portal
    (
        .clk       (MCLK),
        .rst       (RST),
        .ctrl_wr   (REG_WR & hit(REG_INDEX, `PVC_IDX_MMD_CTRL)),
        .data_wr   (REG_WR & hit(REG_INDEX, `PVC_IDX_MMD_DATA)),
        .data_rd   (REG_RD & hit(REG_INDEX, `PVC_IDX_MMD_DATA)),
        .wdata     (REG_WDATA),
        .ctrl_val  (ctrl_val),
        .data_val  (data_val),
        .mmd_dev   (MMD_DEV),
        .mmd_reg   (MMD_REG),
        .mmd_we    (MMD_WE),
        .mmd_re    (MMD_RE),
        .mmd_wdata (MMD_WDATA),
        .mmd_rdata (MMD_RDATA)
    );

    // control / status word, reserved bits read zero
    always @*
    begin
        cs_val                      = 16'h0000;
        cs_val[`PVC_CS_INTPOL_BIT]  = intpol_q;
        cs_val[`PVC_CS_JABBER_BIT]  = jabber_q;
        cs_val[`PVC_CS_SQE_BIT]     = sqe_q;
        cs_val[`PVC_CS_SPD1000_BIT] = SPEED_1000;
        cs_val[`PVC_CS_SPD100_BIT]  = SPEED_100;
        cs_val[`PVC_CS_SPD10_BIT]   = SPEED_10;
        cs_val[`PVC_CS_DUPLEX_BIT]  = DUPLEX_FULL;
        cs_val[`PVC_CS_MASTER_BIT]  = GIG_MASTER;
        cs_val[`PVC_CS_SWRST_BIT]   = swrst_q;
        cs_val[`PVC_CS_LCFAIL_BIT]  = lcfail_q;
    end

    // crossover steering
    assign AUTO_XOVER_EN = ~xover_q[`PVC_XOVER_OFF_BIT];
    assign MDI_SELECT    = xover_q[`PVC_XOVER_OFF_BIT] ?
                           xover_q[`PVC_XOVER_MANUAL_BIT] : AUTO_MDI_RESULT;

    // power-down clock and PLL options
    assign CLOCK_GATE = POWER_DOWN & ~pdtest_q[`PVC_PD_CLKOVR_BIT];
    assign PLL_STOP   = POWER_DOWN & pdtest_q[`PVC_PD_PLLOFF_BIT];

    // static io test drive
    assign IO_TEST_EN    = pdtest_q[`PVC_PD_IOTEST_BIT];
    assign IO_TEST_LEVEL = pdtest_q[`PVC_PD_IOTEST_BIT] &
                           pdtest_q[`PVC_PD_IOLEVEL_BIT];

    // loopback, interrupt level, jabber and sqe
    assign EXT_LOOPBACK   = lpbk_q[`PVC_LPBK_BIT];
    assign INT_PIN        = intpol_q ? INT_REQ : ~INT_REQ;
    assign JABBER_EN      = jabber_q;
    assign SQE_TEST_EN    = sqe_q;
    assign PHY_SOFT_RESET = swrst_q;

    assign REG_RDATA  = rdata_q;
    assign REG_RVALID = rvalid_q;

    // read-to-clear flags, set wins over clear
    always @*
    begin
        swrst_d  = swrst_q;
        lcfail_d = lcfail_q;
        if (rd_cs)
        begin
            swrst_d  = 1'b0;
            lcfail_d = 1'b0;
        end
        if (wr_cs && REG_WDATA[`PVC_CS_SWRST_BIT])
            swrst_d = 1'b1;
        if (LINK_CHECK_FAIL)
            lcfail_d = 1'b1;
    end

    // read data mux, unmapped indices return zero
    always @*
    begin
        case (REG_INDEX)
            `PVC_IDX_MMD_CTRL: rdata_d = ctrl_val;
            `PVC_IDX_MMD_DATA: rdata_d = data_val;
            `PVC_IDX_XOVER:    rdata_d = {8'h00, xover_q[7:6], 6'h00};
            `PVC_IDX_PDTEST:   rdata_d = pdtest_q;
            `PVC_IDX_EXTLPBK:  rdata_d = lpbk_q;
            `PVC_IDX_PHYCTRL:  rdata_d = cs_val;
            default:           rdata_d = 16'h0000;
        endcase
    end

    // next values of the writable registers; unused crossover bits stay zero
    always @*
    begin
        xover_d  = xover_q;
        pdtest_d = pdtest_q;
        lpbk_d   = lpbk_q;
        intpol_d = intpol_q;
        jabber_d = jabber_q;
        sqe_d    = sqe_q;
        if (wr_xover)
        begin
            xover_d[`PVC_XOVER_MANUAL_BIT] = REG_WDATA[`PVC_XOVER_MANUAL_BIT];
            xover_d[`PVC_XOVER_OFF_BIT]    = REG_WDATA[`PVC_XOVER_OFF_BIT];
        end
        if (wr_pdtest)
        begin
            pdtest_d = REG_WDATA;
        end
        if (wr_lpbk)
        begin
            lpbk_d = REG_WDATA;
        end
        if (wr_cs)
        begin
            intpol_d = REG_WDATA[`PVC_CS_INTPOL_BIT];
            jabber_d = REG_WDATA[`PVC_CS_JABBER_BIT];
            sqe_d    = REG_WDATA[`PVC_CS_SQE_BIT];
        end
    end

    // crossover register; the soft reset leaves it alone
    always @(posedge MCLK)
    begin
        if (RST)
        begin
            xover_q <= `PVC_RST_XOVER;
        end
        else
        begin
            xover_q <= xover_d;
        end
    end

    // power-down and io test register
    always @(posedge MCLK)
    begin
        if (RST)
        begin
            pdtest_q <= `PVC_RST_PDTEST;
        end
        else
        begin
            pdtest_q <= pdtest_d;
        end
    end

    // external loopback register
    always @(posedge MCLK)
    begin
        if (RST)
        begin
            lpbk_q <= `PVC_RST_EXTLPBK;
        end
        else
        begin
            lpbk_q <= lpbk_d;
        end
    end

    // control bits of the control/status register
    always @(posedge MCLK)
    begin
        if (RST)
        begin
            intpol_q <= `PVC_RST_INTPOL;
            jabber_q <= `PVC_RST_JABBER;
            sqe_q    <= `PVC_RST_SQE;
        end
        else
        begin
            intpol_q <= intpol_d;
            jabber_q <= jabber_d;
            sqe_q    <= sqe_d;
        end
    end

    // read-to-clear flags
    always @(posedge MCLK)
    begin
        if (RST)
        begin
            swrst_q  <= `PVC_RST_SWRST;
            lcfail_q <= `PVC_RST_LCFAIL;
        end
        else
        begin
            swrst_q  <= swrst_d;
            lcfail_q <= lcfail_d;
        end
    end

    // read strobe echoed as answer valid, one cycle later
    always @(posedge MCLK)
    begin
        if (RST)
        begin
            rvalid_q <= 1'b0;
        end
        else
        begin
            rvalid_q <= REG_RD;
        end
    end

    // read data captured at the strobe, held until the next read
    always @(posedge MCLK)
    begin
        if (RST)
        begin
            rdata_q <= `PVC_RST_RDATA;
        end
        else if (REG_RD)
        begin
            rdata_q <= rdata_d;
        end
    end

endmodule // pvc_vendor_ctrl

//--- test/pvc_mmd_model.sv
`timescale 1ns/1ps

module pvc_mmd_model
(
    input wire        clk,
    input wire [4:0]  dev,
    input wire [15:0] addr,
    input wire        we,
    input wire [15:0] wdata,
    output wire [15:0] rdata
);
    reg [15:0] mem [0:255];
    integer    k;

    // index pattern so unwritten places are recognisable
    initial
    begin
        for (k = 0; k < 256; k = k + 1)
            mem[k] = 16'h5A00 | k[7:0];
    end

    // indirect store, answers at once at the latched place
    assign rdata = mem[{dev[2:0], addr[4:0]}];

    // write strobe lands in the selected place
    always @(posedge clk)
        if (we)
            mem[{dev[2:0], addr[4:0]}] <= wdata;
endmodule // pvc_mmd_model

//--- test/pvc_vendor_ctrl_asserts.sv
`timescale 1ns/1ps

module pvc_vendor_ctrl_asserts
(
    input wire        MCLK,
    input wire        RST,
    input wire [4:0]  REG_INDEX,
    input wire        REG_WR,
    input wire        REG_RD,
    input wire [15:0] REG_WDATA,
    input wire [15:0] REG_RDATA,
    input wire        REG_RVALID,
    input wire [15:0] MMD_REG,
    input wire        MMD_WE,
    input wire        MMD_RE,
    input wire        LINK_CHECK_FAIL,
    input wire        POWER_DOWN,
    input wire        INT_REQ,
    input wire        CLOCK_GATE,
    input wire        PLL_STOP,
    input wire        INT_PIN
);
    reg [1:0] fn_q;
    wire      wr1d = REG_WR && REG_INDEX == 5'h1D;
    wire      wr1f = REG_WR && REG_INDEX == 5'h1F;
    wire      rd1f = REG_RD && REG_INDEX == 5'h1F && !LINK_CHECK_FAIL;

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);

    // portal function last written
    always @(posedge MCLK)
        if (RST)
            fn_q <= 2'h0;
        else if (REG_WR && REG_INDEX == 5'h0D)
            fn_q <= REG_WDATA[15:14];

    a_read_answered: assert property (REG_RD |=> REG_RVALID)
        else $error("read not answered");
    a_clk_override: assert property (wr1d && REG_WDATA[11] ##1 POWER_DOWN |-> !CLOCK_GATE)
        else $error("clock gated despite override");
    a_pll_stop: assert property (wr1d ##1 1 |-> PLL_STOP == (POWER_DOWN && $past(REG_WDATA[10])))
        else $error("pll stop wrong");
    a_int_polarity: assert property (wr1f ##1 1 |-> INT_PIN == ($past(REG_WDATA[14]) ? INT_REQ : !INT_REQ))
        else $error("interrupt level wrong");
    a_fail_seen: assert property (LINK_CHECK_FAIL ##1 !REG_RD ##1 rd1f |=> REG_RDATA[0])
        else $error("link fail flag lost");
    a_fail_cleared: assert property (rd1f && !REG_WR ##1 !REG_WR && !LINK_CHECK_FAIL ##1 rd1f |=> REG_RDATA[1:0] == 2'h0)
        else $error("read did not clear flags");
    a_addr_quiet: assert property (REG_INDEX == 5'h0E && fn_q == 2'h0 |-> !MMD_WE && !MMD_RE)
        else $error("strobe in address phase");
    a_data_hold: assert property ((MMD_WE && fn_q == 2'h1) || (MMD_RE && fn_q == 2'h3) |=> $stable(MMD_REG))
        else $error("address moved");
    a_post_step: assert property ((MMD_WE && fn_q[1]) || (MMD_RE && fn_q == 2'h2) |=> MMD_REG == $past(MMD_REG) + 16'h0001)
        else $error("address not advanced");
endmodule // pvc_vendor_ctrl_asserts

bind pvc_vendor_ctrl pvc_vendor_ctrl_asserts u_chk (.*);

//--- test/tb_pvc_vendor_ctrl.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin num_errors++; \
    $display("[FAIL] %s exp %h got %h", n, e, g); end end

module tb_pvc_vendor_ctrl;
    reg         MCLK = 0, RST = 1, REG_WR = 0, REG_RD = 0, AUTO_MDI_RESULT = 0, SPEED_1000 = 0;
    reg         SPEED_100 = 0, SPEED_10 = 0, DUPLEX_FULL = 0, GIG_MASTER = 0, LINK_CHECK_FAIL = 0;
    reg         POWER_DOWN = 0, INT_REQ = 0;
    reg [4:0]   REG_INDEX = 5'h00;
    reg [15:0]  REG_WDATA = 16'h0000, v;
    wire [15:0] REG_RDATA, MMD_REG, MMD_WDATA, MMD_RDATA;
    wire [4:0]  MMD_DEV;
    wire        REG_RVALID, MMD_WE, MMD_RE, AUTO_XOVER_EN, MDI_SELECT, CLOCK_GATE, PLL_STOP;
    wire        IO_TEST_EN, IO_TEST_LEVEL, EXT_LOOPBACK, INT_PIN, JABBER_EN, SQE_TEST_EN, PHY_SOFT_RESET;
    integer     num_errors = 0, cmp_count = 0, re_count = 0, i;

    always #4 MCLK = ~MCLK;

    // count indirect read strobes seen by the far side
    always @(posedge MCLK)
        if (MMD_RE)
            re_count++;

    pvc_vendor_ctrl dut (.*);
    pvc_mmd_model mmd (.clk(MCLK), .dev(MMD_DEV), .addr(MMD_REG), .we(MMD_WE), .wdata(MMD_WDATA),
        .rdata(MMD_RDATA));

    // one-cycle write strobe
    task wr(input [4:0] a, input [15:0] w);
        @(negedge MCLK);
        REG_INDEX = a;
        REG_WDATA = w;
        REG_WR = 1;
        @(negedge MCLK);
        REG_WR = 0;
    endtask

    // one-cycle read strobe, answer checked a cycle later
    task rd(input [4:0] a, input [15:0] e);
        @(negedge MCLK);
        REG_INDEX = a;
        REG_RD = 1;
        @(negedge MCLK);
        REG_RD = 0;
        `CHK("rvalid", 1'b1, REG_RVALID)
        `CHK("rdata", e, REG_RDATA)
    endtask

    task give_verdict;
        $display("checks %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // watchdog far beyond the roughly 110 cycles needed
    initial
    begin
        #100000;
        num_errors++;
        give_verdict;
    end

    initial
    begin
        repeat (20) @(negedge MCLK);
        RST = 0;
        AUTO_MDI_RESULT = 1;
        rd(5'h1C, 16'h0000);
        `CHK("xover_en", 1'b1, AUTO_XOVER_EN)
        `CHK("mdi_auto", 1'b1, MDI_SELECT)
        wr(5'h1C, 16'hFF40);
        `CHK("xover_en", 1'b0, AUTO_XOVER_EN)
        `CHK("mdi", 1'b0, MDI_SELECT)
        wr(5'h1C, 16'hFFFF);
        `CHK("mdi", 1'b1, MDI_SELECT)
        rd(5'h1C, 16'h00C0);
        AUTO_MDI_RESULT = 0;
        wr(5'h1C, 16'h0080);
        `CHK("xover_en", 1'b1, AUTO_XOVER_EN)
        `CHK("mdi_auto", 1'b0, MDI_SELECT)
        $display("test crossover done");
        POWER_DOWN = 1;
        for (i = 0; i < 4; i++)
        begin
            v = {4'h0, i[1:0], 2'h0, i[1:0], 6'h00};
            wr(5'h1D, v);
            `CHK("clk_gate", !v[11], CLOCK_GATE)
            `CHK("pll_stop", v[10], PLL_STOP)
            `CHK("io_en", v[7], IO_TEST_EN)
            `CHK("io_lvl", v[7] & v[6], IO_TEST_LEVEL)
        end
        rd(5'h1D, 16'h0CC0);
        POWER_DOWN = 0;
        @(negedge MCLK);
        `CHK("clk_gate", 1'b0, CLOCK_GATE)
        `CHK("pll_stop", 1'b0, PLL_STOP)
        wr(5'h1E, 16'h0008);
        `CHK("loopback", 1'b1, EXT_LOOPBACK)
        wr(5'h1E, 16'h0000);
        `CHK("loopback", 1'b0, EXT_LOOPBACK)
        $display("test power and loopback done");
        INT_REQ = 1;
        SPEED_100 = 1;
        DUPLEX_FULL = 1;
        GIG_MASTER = 1;
        @(negedge MCLK);
        `CHK("int_pin", 1'b0, INT_PIN)
        `CHK("jabber", 1'b1, JABBER_EN)
        `CHK("sqe", 1'b1, SQE_TEST_EN)
        rd(5'h1F, 16'h032C);
        wr(5'h1F, 16'h4000);
        `CHK("int_pin", 1'b1, INT_PIN)
        `CHK("jabber", 1'b0, JABBER_EN)
        `CHK("sqe", 1'b0, SQE_TEST_EN)
        wr(5'h1F, 16'h4002);
        `CHK("soft_rst", 1'b1, PHY_SOFT_RESET)
        rd(5'h1F, 16'h402E);
        `CHK("soft_rst", 1'b0, PHY_SOFT_RESET)
        SPEED_100 = 0;
        SPEED_1000 = 1;
        DUPLEX_FULL = 0;
        GIG_MASTER = 0;
        rd(5'h1F, 16'h4040);
        SPEED_1000 = 0;
        SPEED_10 = 1;
        LINK_CHECK_FAIL = 1;
        @(negedge MCLK);
        LINK_CHECK_FAIL = 0;
        rd(5'h1F, 16'h4011);
        rd(5'h1F, 16'h4010);
        rd(5'h05, 16'h0000);
        $display("test control done");
        wr(5'h0D, 16'h0002);
        wr(5'h0E, 16'h0010);
        rd(5'h0E, 16'h0010);
        wr(5'h0D, 16'h4002);
        wr(5'h0E, 16'h0001);
        `CHK("mmd_reg", 16'h0010, MMD_REG)
        rd(5'h0E, 16'h0001);
        wr(5'h0D, 16'h0002);
        wr(5'h0E, 16'h0011);
        wr(5'h0D, 16'h8002);
        for (i = 0; i < 3; i++)
            wr(5'h0E, 16'h0123 + i * 16'h4444);
        `CHK("mmd_reg", 16'h0014, MMD_REG)
        wr(5'h0D, 16'h0002);
        wr(5'h0E, 16'h0011);
        wr(5'h0D, 16'h8002);
        for (i = 0; i < 3; i++)
            rd(5'h0E, 16'h0123 + i * 16'h4444);
        wr(5'h0D, 16'hC002);
        rd(5'h0E, 16'h5A54);
        wr(5'h0E, 16'hBEEF);
        `CHK("mmd_reg", 16'h0015, MMD_REG)
        rd(5'h0D, 16'hC002);
        wr(5'h0D, 16'h0003);
        `CHK("mmd_dev", 5'h03, MMD_DEV)
        `CHK("mmd_reg", 16'h0015, MMD_REG)
        `CHK("mmd_re", 5, re_count)
        $display("test portal done");
        give_verdict;
    end
endmodule // tb_pvc_vendor_ctrl
